// ### rtl/dtc_regs.sv
`timescale 1ns/1ps

module dtc_regs
   import dtc_pkg::*;
(
   input  wire logic           clk_in,
   input  wire logic           nrst_in,
   input  wire logic           ce_in,
   input  wire logic [31:0]    addr_in,
   input  wire logic           wr_in,
   input  wire logic           rd_in,
   input  wire logic [31:0]    wdata_in,
   output logic      [31:0]    rdata_out,
   input  wire logic           underrun_in,
   input  wire logic           pkt_pop_in,
   output dtc_short_pkt_s      pkt_out,
   output logic                pkt_valid_out,
   output logic                eotp_en_out,
   output logic [5:0]          pix_fmt_out,
   output logic                bllp_lp_out,
   output logic [5:0]          filler_dt_out,
   output dtc_vmode_e          vmode_out,
   output logic [1:0]          lanes_out,
   output logic                core_en_out,
   output logic                irq_out
);

   dtc_state_s      r;
   dtc_state_s      next_r;
   logic [6:0]      a;
   logic [5:0]      dt;
   logic            dt_ok;
   logic            push;
   logic            pop;
   logic [2:0]      evt;
   logic [2:0]      w1c;
   logic [31:0]     proto_word;

   assign a  = addr_in[6:0];
   assign dt = wdata_in[POS_DT_LO +: 6];

   always_comb begin
      case (dt)
         6'h07, 6'h02, 6'h12, 6'h22, 6'h32, 6'h03, 6'h13,
         6'h23, 6'h05, 6'h15, 6'h16, 6'h37: dt_ok = 1'b1;
         default: dt_ok = 1'b0;
      endcase
   end

   always_comb begin
      proto_word = 32'h0;
      proto_word[POS_EOTP]            = r.cfg.eotp_en;
      proto_word[POS_PIX_LO +: 6]     = RST_PIX_FMT;
      proto_word[POS_BLLP_LP]         = r.cfg.bllp_lp;
      proto_word[POS_NULL_PKT]        = r.cfg.null_pkt;
      proto_word[POS_VMODE_LO +: 2]   = r.cfg.vmode;
      proto_word[POS_LANES_LO +: 2]   = LANES_CFG;
   end

   always_comb begin
      next_r = r;
      evt    = 3'h0;
      w1c    = 3'h0;
      push   = 1'b0;
      // a single-entry staging slot; vacancy counts free entries, down on a push and up on a pop
      pop    = pkt_pop_in && r.st.pkt_valid;
      if (wr_in) begin
         case (a)
            OFF_CORE_CONFIG: begin
               next_r.cfg.soft_rst = wdata_in[POS_SOFT_RST];
               next_r.cfg.core_en  = wdata_in[POS_CORE_EN];
            end
            OFF_PROTOCOL_CONFIG: begin
               next_r.cfg.eotp_en  = wdata_in[POS_EOTP];
               next_r.cfg.bllp_lp  = wdata_in[POS_BLLP_LP];
               next_r.cfg.null_pkt = wdata_in[POS_NULL_PKT];
               next_r.cfg.vmode    = dtc_vmode_e'(wdata_in[POS_VMODE_LO +: 2]);
            end
            OFF_GLOBAL_IRQ_EN: next_r.cfg.glob_en = wdata_in[0];
            OFF_IRQ_STATUS:    w1c = wdata_in[2:0];
            OFF_IRQ_ENABLE:    next_r.cfg.irq_mask = wdata_in[2:0];
            OFF_CMD_QUEUE_ENTRY: begin
               next_r.st.entry_shadow = {8'h00, wdata_in[23:0]};
               if (!dt_ok) begin
                  evt[POS_BAD_DT] = 1'b1;
               end else if (r.st.vacancy == 6'h00) begin
                  evt[POS_QFULL] = 1'b1;
               end else begin
                  push = 1'b1;
               end
            end
            default: ; // unmapped writes are silently dropped
         endcase
      end
      if (push) begin
         next_r.st.pkt.byte1 = wdata_in[POS_BYTE1_LO +: 8];
         next_r.st.pkt.byte0 = wdata_in[POS_BYTE0_LO +: 8];
         next_r.st.pkt.vc    = wdata_in[POS_VC_LO +: 2];
         next_r.st.pkt.dtype = dt;
         next_r.st.pkt_valid = 1'b1;
      end else if (pop && r.st.vacancy == QUEUE_DEPTH - 6'h01) begin
         next_r.st.pkt_valid = 1'b0;
      end
      case ({push, pop})
         2'b10: next_r.st.vacancy = r.st.vacancy - 6'h01;
         2'b01: next_r.st.vacancy = r.st.vacancy + 6'h01;
         default: ;
      endcase
      // full detected on the write that takes the last free entry
      if (push && !pop && r.st.vacancy == 6'h01) begin
         evt[POS_QFULL] = 1'b1;
      end
      evt[POS_UNDERRUN] = underrun_in;
      // set wins over clear; capture independent of mask
      next_r.st.flags = (r.st.flags & ~w1c) | evt;
      if (next_r.cfg.soft_rst) begin
         next_r.st.flags = 3'h0;
      end
      next_r.st.rdata = 32'h0;
      if (rd_in) begin
         case (a)
            OFF_CORE_CONFIG:     next_r.st.rdata = {29'h0, 1'b1, r.cfg.soft_rst,
                                                    r.cfg.core_en};
            OFF_PROTOCOL_CONFIG: next_r.st.rdata = proto_word;
            OFF_GLOBAL_IRQ_EN:   next_r.st.rdata = {31'h0, r.cfg.glob_en};
            OFF_IRQ_STATUS:      next_r.st.rdata = {29'h0, r.st.flags};
            OFF_IRQ_ENABLE:      next_r.st.rdata = {29'h0, r.cfg.irq_mask};
            OFF_QUEUE_VACANCY:   next_r.st.rdata = {26'h0, r.st.vacancy};
            OFF_CMD_QUEUE_ENTRY: next_r.st.rdata = r.st.entry_shadow;
            default:             next_r.st.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         r.cfg.eotp_en      <= RST_EOTP;
         r.cfg.bllp_lp      <= 1'b0;
         r.cfg.null_pkt     <= 1'b0;
         r.cfg.vmode        <= VM_SYNC_PULSE;
         r.cfg.soft_rst     <= 1'b0;
         r.cfg.core_en      <= 1'b0;
         r.cfg.glob_en      <= 1'b0;
         r.cfg.irq_mask     <= 3'h0;
         r.st.flags         <= 3'h0;
         r.st.vacancy       <= QUEUE_DEPTH;
         r.st.rdata         <= 32'h0;
         r.st.entry_shadow  <= 32'h0;
         r.st.pkt           <= '0;
         r.st.pkt_valid     <= 1'b0;
      end else if (ce_in) begin
         r <= next_r;
      end
   end

   assign rdata_out     = r.st.rdata;
   assign pkt_out       = r.st.pkt;
   assign pkt_valid_out = r.st.pkt_valid;
   assign eotp_en_out   = r.cfg.eotp_en;
   assign pix_fmt_out   = RST_PIX_FMT;
   assign bllp_lp_out   = r.cfg.bllp_lp;
   assign filler_dt_out = r.cfg.null_pkt ? DT_NULL : DT_BLANKING;
   assign vmode_out     = r.cfg.vmode;
   assign lanes_out     = LANES_CFG;
   assign core_en_out   = r.cfg.core_en;
   assign irq_out       = r.cfg.glob_en & |(r.st.flags & r.cfg.irq_mask);

endmodule : dtc_regs

// ### rtl/dtc_pkg.sv
package dtc_pkg;

   // register byte offsets, low seven address bits only
   localparam logic [6:0] OFF_CORE_CONFIG     = 7'h00;
   localparam logic [6:0] OFF_PROTOCOL_CONFIG = 7'h04;
   localparam logic [6:0] OFF_GLOBAL_IRQ_EN   = 7'h20;
   localparam logic [6:0] OFF_IRQ_STATUS      = 7'h24;
   localparam logic [6:0] OFF_IRQ_ENABLE      = 7'h28;
   localparam logic [6:0] OFF_QUEUE_VACANCY   = 7'h2c;
   localparam logic [6:0] OFF_CMD_QUEUE_ENTRY = 7'h30;

   // protocol_config field positions
   localparam int POS_EOTP       = 13;
   localparam int POS_PIX_LO     = 7;
   localparam int POS_BLLP_LP    = 6;
   localparam int POS_NULL_PKT   = 5;
   localparam int POS_VMODE_LO   = 3;
   localparam int POS_LANES_LO   = 0;

   // irq_status bit positions
   localparam int POS_QFULL      = 2;
   localparam int POS_BAD_DT     = 1;
   localparam int POS_UNDERRUN   = 0;

   // core_config bit positions
   localparam int POS_SOFT_RST   = 1;
   localparam int POS_CORE_EN    = 0;

   // command entry field positions
   localparam int POS_BYTE1_LO   = 16;
   localparam int POS_BYTE0_LO   = 8;
   localparam int POS_VC_LO      = 6;
   localparam int POS_DT_LO      = 0;

   // reset values and fixed field values
   localparam logic       RST_EOTP      = 1'b1;
   localparam logic [5:0] RST_PIX_FMT   = 6'h3e;
   localparam logic [1:0] RST_VMODE     = 2'h0;
   localparam logic [5:0] QUEUE_DEPTH   = 6'h20;
   localparam logic [1:0] LANES_CFG     = 2'h3;

   // pixel format data types
   localparam logic [5:0] PIX_RGB565    = 6'h0e;
   localparam logic [5:0] PIX_RGB666P   = 6'h1e;
   localparam logic [5:0] PIX_RGB666L   = 6'h2e;
   localparam logic [5:0] PIX_RGB888    = 6'h3e;
   localparam logic [5:0] PIX_COMPRESS  = 6'h0b;

   // blanking filler data types
   localparam logic [5:0] DT_BLANKING   = 6'h19;
   localparam logic [5:0] DT_NULL       = 6'h09;

   typedef enum logic [1:0] {
      VM_SYNC_PULSE,
      VM_SYNC_EVENT,
      VM_BURST,
      VM_RSVD
   } dtc_vmode_e;

   typedef struct packed {
      logic [7:0] byte1;
      logic [7:0] byte0;
      logic [1:0] vc;
      logic [5:0] dtype;
   } dtc_short_pkt_s;

   typedef struct packed {
      logic       eotp_en;
      logic       bllp_lp;
      logic       null_pkt;
      dtc_vmode_e vmode;
      logic       soft_rst;
      logic       core_en;
      logic       glob_en;
      logic [2:0] irq_mask;
   } dtc_cfg_s;

   typedef struct packed {
      logic     [2:0] flags;
      logic     [5:0] vacancy;
      logic     [31:0] rdata;
      logic     [31:0] entry_shadow;
      dtc_short_pkt_s  pkt;
      logic            pkt_valid;
   } dtc_stat_s;

   typedef struct packed {
      dtc_cfg_s  cfg;
      dtc_stat_s st;
   } dtc_state_s;

endpackage : dtc_pkg

// ### dv/dtc_regs_asserts.sv
`timescale 1ns/1ps
module dtc_regs_asserts
   import dtc_pkg::*;
(
   input wire logic           clk_in,
   input wire logic           nrst_in,
   input wire logic           ce_in,
   input wire logic [31:0]    addr_in,
   input wire logic           wr_in,
   input wire logic           rd_in,
   input wire logic [31:0]    wdata_in,
   input wire logic [31:0]    rdata_out,
   input wire logic           underrun_in,
   input wire logic           pkt_pop_in,
   input wire dtc_short_pkt_s pkt_out,
   input wire logic           pkt_valid_out,
   input wire logic           eotp_en_out,
   input wire logic [5:0]     pix_fmt_out,
   input wire logic           bllp_lp_out,
   input wire logic [5:0]     filler_dt_out,
   input wire dtc_vmode_e     vmode_out,
   input wire logic [1:0]     lanes_out,
   input wire logic           core_en_out,
   input wire logic           irq_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   wire pw = ce_in && wr_in && addr_in[6:0] == OFF_PROTOCOL_CONFIG;
   // only type 0x05 writes are checked, so a full queue keeps the same slot value
   wire qw = ce_in && wr_in && addr_in[6:0] == OFF_CMD_QUEUE_ENTRY && wdata_in[5:0] == 6'h05;
   wire gw = ce_in && wr_in && addr_in[6:0] == OFF_GLOBAL_IRQ_EN && !wdata_in[0];
   property p_eotp; pw |=> eotp_en_out == $past(wdata_in[13]); endproperty
   a_eotp: assert property (p_eotp) else $error("eotp enable not loaded");
   property p_bllp; pw |=> bllp_lp_out == $past(wdata_in[6]); endproperty
   a_bllp: assert property (p_bllp) else $error("blanking mode not loaded");
   property p_fill; pw |=> filler_dt_out == ($past(wdata_in[5]) ? 6'h09 : 6'h19); endproperty
   a_fill: assert property (p_fill) else $error("filler type wrong");
   property p_vmode; pw |=> vmode_out == $past(wdata_in[4:3]); endproperty
   a_vmode: assert property (p_vmode) else $error("video mode not loaded");
   property p_lanes; lanes_out == 2'h3 && pix_fmt_out == 6'h3e; endproperty
   a_lanes: assert property (p_lanes) else $error("fixed fields changed");
   property p_gie; gw |=> !irq_out; endproperty
   a_gie: assert property (p_gie) else $error("irq with global enable low");
   property p_pkt; qw |=> pkt_valid_out && pkt_out == $past(wdata_in[23:0]); endproperty
   a_pkt: assert property (p_pkt) else $error("queue entry fields wrong");
   property p_rdp; ce_in && rd_in && addr_in[6:0] == OFF_PROTOCOL_CONFIG
      |=> rdata_out[31:14] == 18'h0 && rdata_out[12:7] == 6'h3e; endproperty
   a_rdp: assert property (p_rdp) else $error("protocol readback wrong");
endmodule : dtc_regs_asserts

bind dtc_regs dtc_regs_asserts u_chk (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
   .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in),
   .rdata_out(rdata_out), .underrun_in(underrun_in), .pkt_pop_in(pkt_pop_in),
   .pkt_out(pkt_out), .pkt_valid_out(pkt_valid_out), .eotp_en_out(eotp_en_out),
   .pix_fmt_out(pix_fmt_out), .bllp_lp_out(bllp_lp_out), .filler_dt_out(filler_dt_out),
   .vmode_out(vmode_out), .lanes_out(lanes_out), .core_en_out(core_en_out),
   .irq_out(irq_out));

// ### dv/display_tx_ctrl_regs_bench.sv
`timescale 1ns/1ps
module display_tx_ctrl_regs_bench;
   import dtc_pkg::*;
   logic           clk_in, nrst_in, ce_in, wr_in, rd_in, underrun_in, pkt_pop_in;
   logic [31:0]    addr_in, wdata_in, rdata_out;
   logic [5:0]     pix_fmt_out, filler_dt_out;
   logic [1:0]     lanes_out;
   logic           pkt_valid_out, eotp_en_out, bllp_lp_out, core_en_out, irq_out;
   dtc_short_pkt_s pkt_out;
   dtc_vmode_e     vmode_out;
   int             bad_count = 0;
   int             num_checks = 0;
   dtc_regs DUT (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .addr_in(addr_in),
      .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
      .underrun_in(underrun_in), .pkt_pop_in(pkt_pop_in), .pkt_out(pkt_out),
      .pkt_valid_out(pkt_valid_out), .eotp_en_out(eotp_en_out), .pix_fmt_out(pix_fmt_out),
      .bllp_lp_out(bllp_lp_out), .filler_dt_out(filler_dt_out), .vmode_out(vmode_out),
      .lanes_out(lanes_out), .core_en_out(core_en_out), .irq_out(irq_out));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_in);
      #1;
      wr_in = 1;
      addr_in = a;
      wdata_in = d;
      @(posedge clk_in);
      #1;
      wr_in = 0;
   endtask : wr
   // read data is registered, so it is looked at one edge after the strobe
   task rd(input logic [31:0] a, input logic [31:0] exp);
      @(posedge clk_in);
      #1;
      rd_in = 1;
      addr_in = a;
      @(posedge clk_in);
      #1;
      rd_in = 0;
      chk(rdata_out, exp);
   endtask : rd
   task pulse(input logic pop);
      @(posedge clk_in);
      #1;
      if (pop) pkt_pop_in = 1;
      else underrun_in = 1;
      @(posedge clk_in);
      #1;
      pkt_pop_in = 0;
      underrun_in = 0;
   endtask : pulse
   task end_sim;
      if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   initial begin
      clk_in = 0;
      forever #10 clk_in = ~clk_in;
   end
   initial begin
      #100000;
      bad_count++;
      end_sim();
   end
   initial begin
      {nrst_in, wr_in, rd_in, underrun_in, pkt_pop_in} = 5'h0;
      ce_in = 1;
      addr_in = 32'h0;
      wdata_in = 32'h0;
      repeat (20) @(posedge clk_in);
      #1;
      nrst_in = 1;
      rd(32'h04, 32'h3f03);
      rd(32'h2c, 32'h20);
      rd(32'h28, 32'h0);
      rd(32'h20, 32'h0);
      // upper alias 0x84 must reach the protocol register
      for (int v = 0; v < 3; v++) begin
         wr(32'h84, 32'((v << 3) | (v[0] << 5) | (v[1] << 6)));
         chk(vmode_out, v);
         chk(filler_dt_out, v[0] ? 6'h09 : 6'h19);
         chk(bllp_lp_out, v[1]);
         chk(eotp_en_out, 0);
      end
      wr(32'h04, 32'hffffffff);
      rd(32'h04, 32'h3f7b);
      pulse(0);
      rd(32'h24, 32'h1);
      wr(32'h28, 32'h1);
      chk(irq_out, 0);
      wr(32'h20, 32'h1);
      chk(irq_out, 1);
      wr(32'h24, 32'h0);
      rd(32'h24, 32'h1);
      wr(32'h24, 32'h1);
      chk(irq_out, 0);
      wr(32'h30, 32'h00000004);
      rd(32'h24, 32'h2);
      rd(32'h2c, 32'h20);
      wr(32'h30, 32'h00123405);
      chk(pkt_out, 24'h123405);
      rd(32'h30, 32'h00123405);
      rd(32'h2c, 32'h1f);
      pulse(1);
      rd(32'h2c, 32'h20);
      chk(pkt_valid_out, 0);
      wr(32'h24, 32'h7);
      for (int i = 0; i < 33; i++) wr(32'h30, 32'h00123405);
      rd(32'h2c, 32'h0);
      rd(32'h24, 32'h4);
      wr(32'h24, 32'h7);
      wr(32'h00, 32'h2);
      chk(core_en_out, 0);
      pulse(0);
      rd(32'h24, 32'h0);
      wr(32'h00, 32'h1);
      chk(core_en_out, 1);
      rd(32'h00, 32'h5);
      pulse(0);
      rd(32'h24, 32'h1);
      // a frozen clock enable must swallow the event
      wr(32'h24, 32'h1);
      ce_in = 0;
      pulse(0);
      ce_in = 1;
      rd(32'h24, 32'h0);
      wr(32'h20, 32'h0);
      chk(irq_out, 0);
      wr(32'h08, 32'hffffffff);
      rd(32'h08, 32'h0);
      end_sim();
   end
endmodule : display_tx_ctrl_regs_bench
